// [memmap_pkg.sv]
// constants for the core memory map decoder
// assumes a single core clock and synchronous reset
package memmap_pkg;
  localparam int PC_W        = 13;
  localparam int PROG_AW     = 12;
  localparam int INSTR_W     = 14;
  localparam int DATA_W      = 8;
  localparam int BANK_OFF_W  = 7;
  localparam int FILE_AW     = 9;
  localparam int EE_AW       = 8;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR   = 13'h0004;
  localparam int STATUS_BANK_HI = 6;
  localparam int STATUS_BANK_LO = 5;
  localparam logic [6:0] OFF_INDIRECT = 7'h00;
  localparam logic [6:0] OFF_PC_LOW   = 7'h02;
  localparam logic [6:0] OFF_STATUS   = 7'h03;
  localparam logic [6:0] OFF_POINTER  = 7'h04;
  localparam logic [6:0] OFF_PC_LATCH = 7'h0A;
  localparam logic [6:0] OFF_INT_CTRL = 7'h0B;
  localparam logic [6:0] GPR_START    = 7'h20;
  localparam logic [6:0] SHARED_START = 7'h70;
  localparam logic [7:0] STATUS_RESET  = 8'h18;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic [7:0] EE_PTR_RESET  = 8'h00;
  typedef enum logic [1:0] {
    SEL_SFR    = 2'b00,
    SEL_MIRROR = 2'b01,
    SEL_GPR    = 2'b11,
    SEL_SHARED = 2'b10
  } region_t;
endpackage

// [prog_wrap.sv]
// program address folding onto the implemented array
// assumes the program counter comes from logic on the same clock
`timescale 1ns/10ps
module prog_wrap
  import memmap_pkg::*;
#(
  parameter int AW = PROG_AW
)(
  input  wire logic [PC_W-1:0] pc,
  output wire logic [AW-1:0]   word_addr
);
  // upper counter bits dropped
  assign word_addr = pc[AW-1:0];
endmodule

// [memmap_decode.sv]
// program counter, bank select and data space decode for the core
// assumes fetch and data requests from the core on the same clock
`timescale 1ns/10ps
module memmap_decode
  import memmap_pkg::*;
#(
  parameter int PROG_DEPTH = 4096
)(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  pc_load,
  input  wire logic [PC_W-1:0]       pc_load_value,
  input  wire logic                  irq_take,
  input  wire logic                  pc_advance,
  input  wire logic [INSTR_W-1:0]    prog_rdata,
  input  wire logic                  data_req,
  input  wire logic                  data_we,
  input  wire logic [BANK_OFF_W-1:0] instr_offset,
  input  wire logic [DATA_W-1:0]     data_wdata,
  input  wire logic                  ee_ptr_we,
  input  wire logic [EE_AW-1:0]      ee_ptr_wdata,
  output logic [PC_W-1:0]            pc_out,
  output logic [PROG_AW-1:0]         prog_addr,
  output logic [INSTR_W-1:0]         instr_out,
  output logic [FILE_AW-1:0]         file_addr,
  output logic                       sfr_sel,
  output logic                       gpr_sel,
  output logic                       data_we_out,
  output logic [DATA_W-1:0]          data_wdata_out,
  output logic [DATA_W-1:0]          status_out,
  output logic [DATA_W-1:0]          pointer_out,
  output logic [EE_AW-1:0]           ee_ptr_out
);
  logic [PC_W-1:0]      pc_reg;
  logic [PC_W-1:0]      pc_next;
  logic [PROG_AW-1:0]   prog_addr_reg;
  logic [INSTR_W-1:0]   instr_reg;
  logic [FILE_AW-1:0]   file_addr_reg;
  logic                 sfr_sel_reg;
  logic                 gpr_sel_reg;
  logic                 we_reg;
  logic [DATA_W-1:0]    wdata_reg;
  logic [DATA_W-1:0]    status_reg;
  logic [DATA_W-1:0]    status_next;
  logic [DATA_W-1:0]    pointer_reg;
  logic [DATA_W-1:0]    pointer_next;
  logic [EE_AW-1:0]     ee_ptr_reg;
  logic [EE_AW-1:0]     ee_ptr_next;
  wire  logic [PROG_AW-1:0]    folded;
  wire  logic [1:0]            bank;
  wire  logic                  indirect;
  wire  logic [FILE_AW-1:0]    direct_addr;
  wire  logic [FILE_AW-1:0]    indirect_addr;
  wire  logic [FILE_AW-1:0]    eff_addr;
  wire  logic [BANK_OFF_W-1:0] eff_off;
  wire  region_t               region;
  wire  logic                  hit_status;
  wire  logic                  hit_pointer;

  function automatic region_t classify(input logic [BANK_OFF_W-1:0] off);
    region_t r;
    r = SEL_SFR;
    if (off >= SHARED_START)
      r = SEL_SHARED;
    else if (off >= GPR_START)
      r = SEL_GPR;
    else if (off == OFF_STATUS || off == OFF_POINTER ||
             off == OFF_PC_LOW || off == OFF_PC_LATCH ||
             off == OFF_INT_CTRL || off == OFF_INDIRECT)
      r = SEL_MIRROR;
    return r;
  endfunction

  prog_wrap #(.AW(PROG_AW)) u_wrap (
    .pc        (pc_next),
    .word_addr (folded)
  );

  // program counter next value, interrupt over jump over step
  assign pc_next = irq_take   ? IRQ_VECTOR :
                   pc_load    ? pc_load_value :
                   pc_advance ? PC_W'(pc_reg + 1'b1) : pc_reg;

  // bank and address forming
  assign bank          = {status_reg[STATUS_BANK_HI],
                          status_reg[STATUS_BANK_LO]};
  assign direct_addr   = {bank, instr_offset};
  assign indirect      = (instr_offset == OFF_INDIRECT);
  assign indirect_addr = {status_reg[7], pointer_reg};
  assign eff_addr      = indirect ? indirect_addr : direct_addr;
  assign eff_off       = eff_addr[BANK_OFF_W-1:0];
  assign region        = classify(eff_off);
  assign hit_status    = data_req && data_we && (eff_off == OFF_STATUS);
  assign hit_pointer   = data_req && data_we && (eff_off == OFF_POINTER);

  // mirrored core registers, same copy from any bank; the eeprom pointer is loaded only through ee_ptr_we
  assign status_next  = hit_status  ? data_wdata : status_reg;
  assign pointer_next = hit_pointer ? data_wdata : pointer_reg;
  assign ee_ptr_next  = ee_ptr_we ? ee_ptr_wdata : ee_ptr_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pc_reg        <= RESET_VECTOR;
      prog_addr_reg <= RESET_VECTOR[PROG_AW-1:0];
      instr_reg     <= '0;
      status_reg    <= STATUS_RESET;
      pointer_reg   <= POINTER_RESET;
    end
    else
    begin
      pc_reg        <= pc_next;
      prog_addr_reg <= folded;
      instr_reg     <= prog_rdata;
      status_reg    <= status_next;
      pointer_reg   <= pointer_next;
    end
  end

  // data side runs in the same cycle as fetch
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      file_addr_reg <= '0;
      sfr_sel_reg   <= 1'b0;
      gpr_sel_reg   <= 1'b0;
      we_reg        <= 1'b0;
      wdata_reg     <= '0;
      ee_ptr_reg    <= EE_PTR_RESET;
    end
    else
    begin
      file_addr_reg <= eff_addr;
      sfr_sel_reg   <= data_req && (region == SEL_SFR ||
                                    region == SEL_MIRROR);
      gpr_sel_reg   <= data_req && (region == SEL_GPR ||
                                    region == SEL_SHARED);
      we_reg        <= data_req && data_we;
      wdata_reg     <= data_wdata;
      ee_ptr_reg    <= ee_ptr_next;
    end
  end

  assign pc_out         = pc_reg;
  assign prog_addr      = prog_addr_reg;
  assign instr_out      = instr_reg;
  assign file_addr      = file_addr_reg;
  assign sfr_sel        = sfr_sel_reg;
  assign gpr_sel        = gpr_sel_reg;
  assign data_we_out    = we_reg;
  assign data_wdata_out = wdata_reg;
  assign status_out     = status_reg;
  assign pointer_out    = pointer_reg;
  assign ee_ptr_out     = ee_ptr_reg;

  a_reset_vector: assert property (@(posedge clk)
    !rst_n |=> pc_out == RESET_VECTOR && prog_addr == 12'h000)
    else $error("counter not at reset vector after reset");

  a_irq_vector: assert property (@(posedge clk)
    disable iff (!rst_n)
    irq_take |=> pc_out == IRQ_VECTOR && prog_addr == 12'h004)
    else $error("interrupt did not load vector");

  a_wrap_fold: assert property (@(posedge clk)
    disable iff (!rst_n)
    prog_addr == pc_out[11:0])
    else $error("program address not folded from counter");

  a_counter_step: assert property (@(posedge clk)
    disable iff (!rst_n)
    pc_advance && !pc_load && !irq_take |=>
      pc_out == 13'($past(pc_out) + 1'b1))
    else $error("counter step wrong");

  a_pc_hold: assert property (@(posedge clk)
    disable iff (!rst_n)
    !pc_advance && !pc_load && !irq_take |=> $stable(pc_out))
    else $error("counter moved without a request");

  a_load_jump: assert property (@(posedge clk)
    disable iff (!rst_n)
    pc_load && !irq_take |=> pc_out == $past(pc_load_value))
    else $error("jump target not loaded");

  a_bank_direct: assert property (@(posedge clk)
    disable iff (!rst_n)
    data_req && instr_offset != 7'h00 |=>
      file_addr == {$past(status_reg[6]), $past(status_reg[5]),
                    $past(instr_offset)})
    else $error("direct address not formed from bank bits");

  a_indirect_path: assert property (@(posedge clk)
    disable iff (!rst_n)
    data_req && instr_offset == 7'h00 |=>
      file_addr[7:0] == $past(pointer_reg))
    else $error("indirect address not from pointer");

  a_indirect_bank: assert property (@(posedge clk)
    disable iff (!rst_n)
    data_req && indirect |=> file_addr[8] == $past(status_reg[7]))
    else $error("indirect bank bit not from status");

  a_region_split: assert property (@(posedge clk)
    disable iff (!rst_n)
    data_req && eff_off >= 7'h20 |=> gpr_sel && !sfr_sel)
    else $error("upper offsets not decoded to ram");

  a_low_sfr: assert property (@(posedge clk)
    disable iff (!rst_n)
    data_req && eff_off < GPR_START |=> sfr_sel && !gpr_sel)
    else $error("low offsets not decoded to special registers");

  a_status_mirror: assert property (@(posedge clk)
    disable iff (!rst_n)
    hit_status |=> status_out == $past(data_wdata))
    else $error("status write lost in some bank");

  a_ee_pointer: assert property (@(posedge clk)
    disable iff (!rst_n)
    ee_ptr_we |=> ee_ptr_out == $past(ee_ptr_wdata))
    else $error("eeprom pointer not loaded");

  a_ee_offmap: assert property (@(posedge clk)
    disable iff (!rst_n)
    !ee_ptr_we |=> $stable(ee_ptr_out))
    else $error("eeprom pointer moved by a data access");
endmodule

// [core_fetch_model.sv]
// program array stand-in answering fetches from the decoder
// assumes prog_addr comes straight from the decoder's register
`timescale 1ns/10ps
module core_fetch_model
  import memmap_pkg::*;
(
  input  wire logic [PROG_AW-1:0] prog_addr,
  output logic [INSTR_W-1:0]      prog_rdata
);
  // word content tied to its array address only
  assign prog_rdata = {2'b10, prog_addr ^ 12'hA5A};
endmodule

// [core_memory_map_decode_tb_top.sv]
// self-checking bench for memmap_decode with a program array model
// assumes a 100 MHz core clock and synchronous active-low reset
`timescale 1ns/10ps
module core_memory_map_decode_tb_top
  import memmap_pkg::*;
;
  logic clk, rst_n, pc_load, irq_take, pc_advance, data_req, data_we;
  logic ee_ptr_we;
  logic [PC_W-1:0]       pc_load_value, pc_out;
  logic [INSTR_W-1:0]    prog_rdata, instr_out;
  logic [BANK_OFF_W-1:0] instr_offset;
  logic [DATA_W-1:0]     data_wdata, data_wdata_out, status_out;
  logic [DATA_W-1:0]     pointer_out, ee_ptr_wdata, ee_ptr_out;
  logic [PROG_AW-1:0]    prog_addr;
  logic [FILE_AW-1:0]    file_addr;
  logic                  sfr_sel, gpr_sel, data_we_out;
  int                    fails, check_count, cycles;
  logic [INSTR_W-1:0]    word_hi;
  memmap_decode uut (.clk(clk), .rst_n(rst_n), .pc_load(pc_load),
    .pc_load_value(pc_load_value), .irq_take(irq_take),
    .pc_advance(pc_advance), .prog_rdata(prog_rdata), .data_req(data_req),
    .data_we(data_we), .instr_offset(instr_offset),
    .data_wdata(data_wdata), .ee_ptr_we(ee_ptr_we),
    .ee_ptr_wdata(ee_ptr_wdata), .pc_out(pc_out), .prog_addr(prog_addr),
    .instr_out(instr_out), .file_addr(file_addr), .sfr_sel(sfr_sel),
    .gpr_sel(gpr_sel), .data_we_out(data_we_out),
    .data_wdata_out(data_wdata_out), .status_out(status_out),
    .pointer_out(pointer_out), .ee_ptr_out(ee_ptr_out));
  core_fetch_model fetch (.prog_addr(prog_addr), .prog_rdata(prog_rdata));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      conclude();
    end
  end
  task check(input string name, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task step;
    @(posedge clk);
    #1;
  endtask
  task t_reset;
    rst_n = 1'b0;
    step();
    rst_n = 1'b1;
    check("pc_out", 16'(pc_out), 16'h0000);
    check("prog_addr", 16'(prog_addr), 16'h0000);
    check("status", 16'(status_out), 16'h0018);
    check("pointer", 16'(pointer_out), 16'h0000);
    check("ee_ptr", 16'(ee_ptr_out), 16'h0000);
    check("selects", 16'({sfr_sel, gpr_sel}), 16'h0000);
    $display("test reset done");
  endtask
  task load(input logic [12:0] v);
    pc_load = 1'b1;
    pc_load_value = v;
    step();
    pc_load = 1'b0;
    step();
  endtask
  task t_prog;
    load(13'h1C20);
    check("pc_out", 16'(pc_out), 16'h1C20);
    check("prog_addr", 16'(prog_addr), 16'h0C20);
    word_hi = instr_out;
    check("instr", 16'(instr_out), 16'({2'b10, 12'hC20 ^ 12'hA5A}));
    load(13'h0C20);
    check("instr wrap", 16'(instr_out), 16'(word_hi));
    load(13'h0FFF);
    pc_advance = 1'b1;
    step();
    pc_advance = 1'b0;
    check("pc_out", 16'(pc_out), 16'h1000);
    check("prog_addr", 16'(prog_addr), 16'h0000);
    $display("test program space done");
  endtask
  task t_irq;
    step();
    {pc_load, irq_take, pc_advance} = 3'b111;
    pc_load_value = 13'h0123;
    step();
    check("irq pc", 16'(pc_out), 16'h0004);
    irq_take = 1'b0;
    step();
    check("load pc", 16'(pc_out), 16'h0123);
    pc_load = 1'b0;
    step();
    pc_advance = 1'b0;
    check("adv pc", 16'(pc_out), 16'h0124);
    $display("test interrupt done");
  endtask
  task access(input logic [6:0] off, input logic we, input logic [7:0] wd);
    {data_req, data_we, instr_offset, data_wdata} = {1'b1, we, off, wd};
    step();
  endtask
  task t_data;
    for (int b = 0; b < 4; b++)
    begin
      access(7'h03, 1'b1, {1'b0, 2'(b), 5'h00});
      check("status", 16'(status_out), 16'({1'b0, 2'(b), 5'h00}));
      check("we_out", 16'({data_we_out, data_wdata_out}),
            16'({1'b1, 1'b0, 2'(b), 5'h00}));
      access(7'h1F, 1'b0, 8'h00);
      check("sfr addr", 16'({sfr_sel, gpr_sel, file_addr}),
            16'({2'b10, 2'(b), 7'h1F}));
      access(7'h20, 1'b0, 8'h00);
      check("gpr addr", 16'({sfr_sel, gpr_sel, file_addr}),
            16'({2'b01, 2'(b), 7'h20}));
      access(7'h7F, 1'b0, 8'h00);
      check("top addr", 16'(file_addr), 16'({2'(b), 7'h7F}));
    end
    access(7'h04, 1'b1, 8'h55);
    check("pointer", 16'(pointer_out), 16'h0055);
    access(7'h00, 1'b0, 8'h00);
    check("indirect", 16'(file_addr), 16'h0055);
    access(7'h03, 1'b1, 8'hE0);
    access(7'h00, 1'b0, 8'h00);
    check("indirect hi", 16'(file_addr), 16'h0155);
    {data_req, data_we} = 2'b01;
    step();
    data_we = 1'b0;
    check("stray we", 16'(data_we_out), 16'h0000);
    ee_ptr_we = 1'b1;
    ee_ptr_wdata = 8'hFF;
    step();
    ee_ptr_we = 1'b0;
    check("ee_ptr", 16'(ee_ptr_out), 16'h00FF);
    check("status kept", 16'(status_out), 16'h00E0);
    $display("test data space done");
  endtask
  initial
  begin
    {rst_n, pc_load, irq_take, pc_advance, data_req, data_we} = '0;
    {ee_ptr_we, pc_load_value, instr_offset, data_wdata} = '0;
    ee_ptr_wdata = '0;
    repeat (6) @(posedge clk);
    #1;
    t_reset();
    t_prog();
    t_irq();
    t_data();
    t_reset();
    conclude();
  end
endmodule
